// ===== src/fault_summary_and_power_mode_regs.sv
// What this block does
// - Tuning C resets 0x04, accepts 0x00 too.
// - Tuning D resets 0x1B, accepts 0x14 too.
// - Summary bit 0 is any unmasked flag.
// - Per-flag mask removes it from summary.
// - Summary drives the calibration-status pin when selected.
// - Flags reset 0x3F; writing one clears.
// - Flag 5 sets on lane buffer fault while the serial link is enabled.
// - Flag 3 sets on link not up or realign.
// - All flags read one after any reset.
// - Flag 0 sets on divider mismatch.
`timescale 1ns/1ps
`include "fault_power_defines.svh"

module fault_summary_and_power_mode_regs #(
   parameter int LANES = 8
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic soft_rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe_n,
   input wire logic [LANES-1:0] lane_buffer_fault,
   input wire logic serializer_pll_unlock,
   input wire logic serial_link_enable,
   input wire logic data_phase_state,
   input wire logic link_64b66b,
   input wire logic link_realign_event,
   input wire logic sysref_realign_event,
   input wire logic [7:0] divider_ab,
   input wire logic [7:0] divider_cd,
   input wire fault_power_pkg::cal_source_t cal_status_sel,
   input wire logic cal_done,
   output logic cal_status_pin,
   output logic [7:0] power_setting_c,
   output logic [7:0] power_setting_d,
   output logic fault_summary
);
   import fault_power_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Serial configuration port.
   cfg_req_t req;
   logic [14:0] rd_addr;
   logic [7:0] rdata;

   serial_cfg_port port_inst (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .sclk(sclk),
      .cs_n(cs_n),
      .sdi(sdi),
      .req(req),
      .rd_addr(rd_addr),
      .rdata(rdata),
      .sdo(sdo),
      .sdo_oe_n(sdo_oe_n)
   );

   function automatic logic hit(input cfg_req_t r, input logic [14:0] a);
      hit = r.valid && r.write && r.addr == a;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Write decode. Reserved power codes are refused and leave the value.
   logic [`FLAG_BITS-1:0] flags;
   logic [`FLAG_BITS-1:0] mask;
   logic [`FLAG_BITS-1:0] set_vec;

   wire any_rst = sys_rst || soft_rst;
   wire wr_c = hit(req, `ADDR_POWER_TUNING_C);
   wire wr_d = hit(req, `ADDR_POWER_TUNING_D);
   wire wr_flags = hit(req, `ADDR_FAULT_FLAGS);
   wire wr_mask = hit(req, `ADDR_FAULT_MASK);
   wire legal_c = req.wdata == `POWER_C_HIGH_PERF ||
                  req.wdata == `POWER_C_LOW_POWER;
   wire legal_d = req.wdata == `POWER_D_HIGH_PERF ||
                  req.wdata == `POWER_D_LOW_POWER;
   wire [`FLAG_BITS-1:0] clr_vec =
      wr_flags ? req.wdata[`FLAG_BITS-1:0] : '0;

   ////////////////////////////////////////////////////////////////////////
   // Fault event sources.
   wire link_not_up = serial_link_enable &&
      (link_64b66b ? link_realign_event : !data_phase_state);

   always_comb begin
      set_vec = '0;
      set_vec[`FLAG_LANE] = serial_link_enable && |lane_buffer_fault;
      set_vec[`FLAG_PLL] = serializer_pll_unlock;
      set_vec[`FLAG_LINK] = link_not_up;
      set_vec[`FLAG_REALIGN] = sysref_realign_event;
      set_vec[`FLAG_DIVIDER] = divider_ab != divider_cd;
   end

   wire [`FLAG_BITS-1:0] next_flags = (flags & ~clr_vec) | set_vec;
   wire [`FLAG_BITS-1:0] next_mask =
      wr_mask ? req.wdata[`FLAG_BITS-1:0] : mask;
   wire next_summary = |(next_flags & ~next_mask);
   wire next_pin =
      cal_status_sel == src_fault_summary ? next_summary : cal_done;

   ////////////////////////////////////////////////////////////////////////
   // Register storage.
   always_ff @(posedge sys_clk) begin
      if (any_rst) begin
         flags <= `FAULT_FLAGS_RESET;
         mask <= `FAULT_MASK_RESET;
         power_setting_c <= `POWER_C_HIGH_PERF;
         power_setting_d <= `POWER_D_HIGH_PERF;
         fault_summary <= 1'b0;
         cal_status_pin <= 1'b0;
      end else begin
         flags <= next_flags;
         mask <= next_mask;
         if (wr_c && legal_c) begin
            power_setting_c <= req.wdata;
         end
         if (wr_d && legal_d) begin
            power_setting_d <= req.wdata;
         end
         fault_summary <= next_summary;
         cal_status_pin <= next_pin;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read multiplexer; unmapped addresses read zero.
   wire [7:0] flags_word = {2'b00, flags};
   wire [7:0] mask_word = {2'b00, mask};
   wire [7:0] summary_word = {7'h00, fault_summary};

   assign rdata =
      rd_addr == `ADDR_POWER_TUNING_C ? power_setting_c :
      rd_addr == `ADDR_POWER_TUNING_D ? power_setting_d :
      rd_addr == `ADDR_FAULT_SUMMARY ? summary_word :
      rd_addr == `ADDR_FAULT_FLAGS ? flags_word :
      rd_addr == `ADDR_FAULT_MASK ? mask_word : 8'h00;
endmodule

// ===== src/fault_power_defines.svh
`ifndef FAULT_POWER_DEFINES_SVH
`define FAULT_POWER_DEFINES_SVH

// Register offsets on the serial configuration port.
`define ADDR_POWER_TUNING_C 15'h029B
`define ADDR_POWER_TUNING_D 15'h029C
`define ADDR_FAULT_SUMMARY 15'h02C0
`define ADDR_FAULT_FLAGS 15'h02C1
`define ADDR_FAULT_MASK 15'h02C2

// Reset values and legal codes.
`define POWER_C_HIGH_PERF 8'h04
`define POWER_C_LOW_POWER 8'h00
`define POWER_D_HIGH_PERF 8'h1B
`define POWER_D_LOW_POWER 8'h14
`define FAULT_FLAGS_RESET 6'h3F
`define FAULT_MASK_RESET 6'h3F

// Fault flag bit positions.
`define FLAG_DIVIDER 0
`define FLAG_REALIGN 2
`define FLAG_LINK 3
`define FLAG_PLL 4
`define FLAG_LANE 5
`define FLAG_BITS 6

// Serial frame layout: read bit, 15 address bits, 8 data bits.
`define FRAME_BITS 5'd24
`define FRAME_ADDR_DONE 5'd16
`define FRAME_READ_BIT 23

`endif

// ===== src/fault_power_pkg.sv
package fault_power_pkg;

   typedef struct packed {
      logic valid;
      logic write;
      logic [14:0] addr;
      logic [7:0] wdata;
   } cfg_req_t;

   typedef enum logic {
      src_other,
      src_fault_summary
   } cal_source_t;

endpackage

// ===== src/serial_cfg_port.sv
`timescale 1ns/1ps
`include "fault_power_defines.svh"

module serial_cfg_port (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output fault_power_pkg::cfg_req_t req,
   output logic [14:0] rd_addr,
   input wire logic [7:0] rdata,
   output logic sdo,
   output logic sdo_oe_n
);
   import fault_power_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Three-stage synchronisers; a change counts when stages two and three
   // agree and differ from the last accepted level.
   logic [2:0] sclk_sync;
   logic [2:0] cs_sync;
   logic [2:0] sdi_sync;
   logic sclk_lvl;
   logic cs_lvl;
   logic sdi_lvl;

   always_ff @(posedge sys_clk) begin
      sclk_sync <= {sclk_sync[1:0], sclk};
      cs_sync <= {cs_sync[1:0], cs_n};
      sdi_sync <= {sdi_sync[1:0], sdi};
   end

   wire sclk_steady = sclk_sync[1] == sclk_sync[2];
   wire cs_steady = cs_sync[1] == cs_sync[2];
   wire sdi_steady = sdi_sync[1] == sdi_sync[2];
   wire sclk_rise = sclk_steady && sclk_sync[2] && !sclk_lvl;
   wire sclk_fall = sclk_steady && !sclk_sync[2] && sclk_lvl;
   wire next_cs_lvl = cs_steady ? cs_sync[2] : cs_lvl;
   wire next_sdi = sdi_steady ? sdi_sync[2] : sdi_lvl;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sclk_lvl <= 1'b0;
         cs_lvl <= 1'b1;
         sdi_lvl <= 1'b0;
      end else begin
         if (sclk_steady) begin
            sclk_lvl <= sclk_sync[2];
         end
         cs_lvl <= next_cs_lvl;
         sdi_lvl <= next_sdi;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame shifter.
   logic [23:0] shift;
   logic [4:0] count;
   logic [7:0] out_shift;
   logic is_read;

   wire active = !next_cs_lvl;
   wire [23:0] next_shift = {shift[22:0], next_sdi};
   wire [4:0] next_count = count + 5'd1;
   wire frame_end = active && sclk_rise && next_count == `FRAME_BITS;
   wire addr_done = active && sclk_rise && next_count == `FRAME_ADDR_DONE;

   // The address is complete only with the bit being taken, so the read
   // word is looked up from the incoming shift value.
   assign rd_addr = next_shift[14:0];

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         shift <= 24'h000000;
         count <= 5'h00;
         out_shift <= 8'h00;
         req <= '0;
         sdo <= 1'b0;
         sdo_oe_n <= 1'b1;
         is_read <= 1'b0;
      end else begin
         req.valid <= 1'b0;
         if (!active) begin
            count <= 5'h00;
            sdo_oe_n <= 1'b1;
         end else if (sclk_rise) begin
            shift <= next_shift;
            count <= next_count;
            if (frame_end) begin
               req.valid <= 1'b1;
               req.write <= !next_shift[`FRAME_READ_BIT];
               req.addr <= next_shift[22:8];
               req.wdata <= next_shift[7:0];
            end
         end else if (sclk_fall && count >= `FRAME_ADDR_DONE && is_read
                      && count < `FRAME_BITS) begin
            sdo <= out_shift[7];
            out_shift <= {out_shift[6:0], 1'b0};
            sdo_oe_n <= 1'b0;
         end
         if (addr_done) begin
            out_shift <= rdata;
            // The read bit sits just above the address once it is in.
            is_read <= next_shift[`FRAME_ADDR_DONE - 1];
         end
      end
   end
endmodule

// ===== testbench/fault_regs_sva.sv
`timescale 1ns/1ps
`include "fault_power_defines.svh"
module fault_regs_sva (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic soft_rst,
   input wire logic cs_n,
   input wire logic sdo_oe_n,
   input wire fault_power_pkg::cal_source_t cal_status_sel,
   input wire logic cal_done,
   input wire logic cal_status_pin,
   input wire logic [7:0] power_setting_c,
   input wire logic [7:0] power_setting_d,
   input wire logic fault_summary
);
   import fault_power_pkg::*;
   wire logic rst = sys_rst | soft_rst;
   default clocking cb @(posedge sys_clk); endclocking
   property p_pin_sum;
      disable iff (rst) cal_status_sel == src_fault_summary |=>
         cal_status_pin == fault_summary;
   endproperty
   a_pin_sum: assert property (p_pin_sum) else $error("pin bad");
   property p_pin_done;
      disable iff (rst) cal_status_sel == src_other |=>
         cal_status_pin == $past(cal_done);
   endproperty
   a_pin_done: assert property (p_pin_done) else $error("pin bad");
   property p_c_legal;
      disable iff (rst) power_setting_c inside {8'h00, 8'h04};
   endproperty
   a_c_legal: assert property (p_c_legal) else $error("c bad");
   property p_d_legal;
      disable iff (rst) power_setting_d inside {8'h14, 8'h1B};
   endproperty
   a_d_legal: assert property (p_d_legal) else $error("d bad");
   property p_hold;
      disable iff (rst) cs_n [*8] |=>
         $stable(power_setting_c) && $stable(power_setting_d);
   endproperty
   a_hold: assert property (p_hold) else $error("c/d moved");
   property p_oe_idle;
      disable iff (rst) cs_n [*8] |-> sdo_oe_n;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("sdo driven");
   property p_rst_pwr;
      rst |=> power_setting_c == `POWER_C_HIGH_PERF &&
         power_setting_d == `POWER_D_HIGH_PERF;
   endproperty
   a_rst_pwr: assert property (p_rst_pwr) else $error("rst c/d");
   property p_rst_sum;
      rst |=> !fault_summary && !cal_status_pin;
   endproperty
   a_rst_sum: assert property (p_rst_sum) else $error("rst sum");
endmodule
bind fault_summary_and_power_mode_regs fault_regs_sva u_sva (.sys_clk,
   .sys_rst, .soft_rst, .cs_n, .sdo_oe_n, .cal_status_sel, .cal_done,
   .cal_status_pin, .power_setting_c, .power_setting_d, .fault_summary);

// ===== testbench/fault_summary_and_power_mode_regs_tb_top.sv
`timescale 1ns/1ps
`include "fault_power_defines.svh"
module fault_summary_and_power_mode_regs_tb_top;
   import fault_power_pkg::*;
   logic sys_clk = 0, sys_rst = 1, soft_rst = 0, sclk = 0, cs_n = 1;
   logic sdi = 0, lnk = 0, dps = 1, m64 = 0, lre = 0, sre = 0, pll = 0;
   logic cd = 0, sdo, oe_n, pin, summ, race = 0;
   logic [7:0] lane = 0, dab = 0, dcd = 0, pc, pd, pco, pdo, q, v, fl, e;
   logic [7:0] cv [4] = '{8'h00, 8'h14, 8'h04, 8'h1B};
   int bt [6] = '{0, 2, 3, 4, 5, 3};
   cal_source_t sel = src_other;
   int n_errors = 0, tests_run = 0, seed = 32'h34DA0885;
   fault_summary_and_power_mode_regs u_dut (.sys_clk, .sys_rst, .soft_rst,
      .sclk, .cs_n, .sdi, .sdo, .sdo_oe_n(oe_n), .lane_buffer_fault(lane),
      .serializer_pll_unlock(pll), .serial_link_enable(lnk),
      .data_phase_state(dps), .link_64b66b(m64), .link_realign_event(lre),
      .sysref_realign_event(sre), .divider_ab(dab), .divider_cd(dcd),
      .cal_status_sel(sel), .cal_done(cd), .cal_status_pin(pin),
      .power_setting_c(pco), .power_setting_d(pdo), .fault_summary(summ));
   initial forever #5 sys_clk = ~sys_clk;
   task summarize;
      if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [7:0] g, x);
      tests_run++;
      if (g !== x) begin
         n_errors++;
         $display("BAD %0t %h %h", $time, g, x);
      end
   endtask
   task w(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // One 24-bit frame; read data is sampled late in each low phase.
   // With race set, a realign event pulses in the cycle the write lands.
   task xfer(input logic r, input logic [14:0] a, input logic [7:0] d);
      logic [23:0] b;
      b = {r, a, d};
      cs_n = 0;
      for (int i = 23; i >= 0; i--) begin
         sdi = b[i];
         w(6);
         if (i < 8) q[i] = sdo;
         sclk = 1;
         if (i == 0 && race) begin
            w(4);
            sre = 1;
            w(1);
            sre = 0;
            w(1);
         end else begin
            w(6);
         end
         sclk = 0;
      end
      w(6);
      cs_n = 1;
      w(10);
   endtask
   task wr(input logic [14:0] a, input logic [7:0] d);
      xfer(1'b0, a, d);
   endtask
   task rd(input logic [14:0] a, input logic [7:0] x);
      xfer(1'b1, a, 8'h00);
      chk(q, x);
   endtask
   function automatic logic [7:0] pick(logic [7:0] o, n, a, b);
      return (n === a || n === b) ? n : o;
   endfunction
   initial begin
      #500000;
      n_errors++;
      summarize;
   end
   initial begin
      w(12);
      sys_rst = 0;
      w(6);
      rd(`ADDR_FAULT_FLAGS, 8'h3F);
      rd(`ADDR_FAULT_SUMMARY, 8'h00);
      pc = `POWER_C_HIGH_PERF;
      pd = `POWER_D_HIGH_PERF;
      for (int i = 0; i < 8; i++) begin
         v = i < 4 ? cv[i] : 8'($random(seed));
         if (i == 0) rd(`ADDR_POWER_TUNING_C, pc);
         if (i == 0) rd(`ADDR_POWER_TUNING_D, pd);
         wr(`ADDR_POWER_TUNING_C, v);
         wr(`ADDR_POWER_TUNING_D, v);
         pc = pick(pc, v, `POWER_C_LOW_POWER, `POWER_C_HIGH_PERF);
         pd = pick(pd, v, `POWER_D_LOW_POWER, `POWER_D_HIGH_PERF);
         rd(`ADDR_POWER_TUNING_C, pc);
         rd(`ADDR_POWER_TUNING_D, pd);
         chk(pdo ^ pco, pd ^ pc);
      end
      wr(`ADDR_POWER_TUNING_C, `POWER_C_LOW_POWER);
      wr(`ADDR_POWER_TUNING_D, `POWER_D_LOW_POWER);
      chk(pco, `POWER_C_LOW_POWER);
      chk(pdo, `POWER_D_LOW_POWER);
      cd = 1;
      w(3);
      cd = 0;
      wr(`ADDR_FAULT_MASK, 8'h00);
      fl = 8'h3F;
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         wr(`ADDR_FAULT_FLAGS, v);
         fl = fl & ~v & 8'h3F;
         rd(`ADDR_FAULT_FLAGS, fl);
         chk({7'h0, summ}, {7'h0, |fl});
      end
      wr(`ADDR_FAULT_FLAGS, 8'hFF);
      for (int i = 0; i < 6; i++) begin
         case (i)
            0: dab = 8'h01;
            1: sre = 1;
            2: {lnk, dps} = 2'b10;
            3: pll = 1;
            4: {lnk, lane} = {1'b1, 8'h80};
            default: {lnk, m64, lre} = 3'b111;
         endcase
         w(3);
         {dab, sre, pll, lane, lre, lnk, m64, dps} = 22'h1;
         e = 8'h01 << bt[i];
         wr(`ADDR_FAULT_MASK, 8'h3F ^ e);
         rd(`ADDR_FAULT_FLAGS, e);
         chk({7'h0, summ}, 8'h01);
         wr(`ADDR_FAULT_MASK, e);
         rd(`ADDR_FAULT_FLAGS, e);
         chk({7'h0, summ}, 8'h00);
         wr(`ADDR_FAULT_FLAGS, e);
      end
      wr(`ADDR_FAULT_MASK, 8'h00);
      pll = 1;
      w(3);
      sel = src_fault_summary;
      w(3);
      chk({6'h0, pin, summ}, 8'h03);
      sel = src_other;
      for (int i = 0; i < 4; i++) begin
         cd = 1'($random(seed));
         w(3);
         chk({7'h0, pin}, {7'h0, cd});
      end
      wr(`ADDR_FAULT_SUMMARY, 8'h00);
      rd(`ADDR_FAULT_SUMMARY, 8'h01);
      wr(`ADDR_FAULT_FLAGS, 8'h10);
      rd(`ADDR_FAULT_FLAGS, 8'h10);
      race = 1;
      wr(`ADDR_FAULT_FLAGS, 8'h04);
      race = 0;
      rd(`ADDR_FAULT_FLAGS, 8'h14);
      pll = 0;
      wr(`ADDR_FAULT_FLAGS, 8'hFF);
      rd(`ADDR_FAULT_FLAGS, 8'h00);
      rd(15'h0123, 8'h00);
      soft_rst = 1;
      w(2);
      soft_rst = 0;
      w(6);
      rd(`ADDR_POWER_TUNING_C, `POWER_C_HIGH_PERF);
      rd(`ADDR_POWER_TUNING_D, `POWER_D_HIGH_PERF);
      rd(`ADDR_FAULT_FLAGS, 8'h3F);
      summarize;
   end
endmodule
